// ### osc_regs.svh
// constants of the output sequence slot controller
`ifndef OSC_REGS_SVH
`define OSC_REGS_SVH
`define OSC_SLOTS 10
`define OSC_SLOT_MIN 1
`define OSC_SLOT_RST 4'h1
`define OSC_CHAIN_RST 4'h0
`define OSC_STEP_MAX 150
`define OSC_STEP_MIN 1
`define OSC_STEP_RST 8'h01
`define OSC_TOTAL_MIN 2
`define OSC_TOTAL_RST 8'h02
`define OSC_REP_MIN 1
`define OSC_REP_MAX 50000
`define OSC_REP_RST 16'h0001
`define OSC_HOLD_MIN 1
`define OSC_HOLD_MAX 200000
`define OSC_HOLD_RST 18'h00001
`define OSC_HOLD_LSB_NS 10000000
`define OSC_CLK_PERIOD_NS 5
`endif

// ### osc_pkg.sv
// types of the output sequence slot controller
package osc_pkg;
   typedef enum logic [3:0] {
      OSC_OP_SLOT_SEL, OSC_OP_CLEAR, OSC_OP_CLEAR_ALL, OSC_OP_CHAIN, OSC_OP_REPEAT,
      OSC_OP_RUN, OSC_OP_SAVE, OSC_OP_STEP_SEL, OSC_OP_CUR1, OSC_OP_CUR2,
      OSC_OP_HOLD, OSC_OP_TOTAL
   } osc_op_t;
   typedef struct packed {
      osc_op_t op;
      logic query;
      logic [31:0] value;
   } osc_cmd_t;
   typedef struct packed {
      logic err;
      logic [31:0] data;
   } osc_rsp_t;
   typedef struct packed {
      logic [15:0] cur1;
      logic [15:0] cur2;
      logic [17:0] hold;
   } osc_step_t;
   typedef enum logic [1:0] {OSC_IDLE, OSC_SAVE, OSC_LOAD, OSC_HOLD} osc_state_t;
endpackage

// ### osc_ctrl.sv
// output sequence slot controller: command interpreter, slot store and sequencer
//
// How it works
// - the clear command empties only the slot picked by the slot select.
// - the clear-all command empties all ten slots.
// - the chained slot takes 0 to 10, 0 meaning nothing follows, and reads back as stored.
// - when a run finishes with a non-zero chained slot the sequencer goes on with that slot.
// - the repeat count takes 1 to 50000 and the selected slot runs that many passes.
// - writing a non-zero value to the run control starts the selected slot.
// - a run control query answers 1 while a sequence runs and 0 otherwise.
// - the save command copies the edited sequence into the selected slot.
// - the step select takes 1 to 150 and picks the step that step writes and queries use.
// - the channel-1 current of the selected step is stored and read back, 0 to rated maximum.
// - the channel-2 current exists only on dual units and otherwise is refused.
// - the slot select takes 1 to 10 and reads back as stored.
// - each step holds its set-points for its own time of 10 ms to 2000 s.
// - the step total takes 2 to 150 and fixes the length of the sequence.
`timescale 1ns/100ps
`include "osc_regs.svh"
module osc_ctrl #(
   parameter int CUR_W = 16,
   parameter logic [15:0] CUR_MAX = 16'hffff,
   parameter bit DUAL = 1'b1,
   parameter int TICK_CYCLES = `OSC_HOLD_LSB_NS / `OSC_CLK_PERIOD_NS
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic cmd_valid,
   input osc_pkg::osc_cmd_t cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output osc_pkg::osc_rsp_t rsp,
   output logic run_active,
   output logic step_strobe,
   output logic [15:0] set_cur1,
   output logic [15:0] set_cur2
);
   import osc_pkg::*;

   localparam int NSTEP = `OSC_STEP_MAX;
   localparam int NWORD = `OSC_SLOTS * `OSC_STEP_MAX;

   // the step record and addressing are sized for 16-bit currents and a 24-bit tick count;
   // a slower tick would need a wider hold timer, so such values are refused here
   if (CUR_W != 16 || TICK_CYCLES < 1 || TICK_CYCLES > 24'hffffff) begin : g_param_check
      $error("osc_ctrl: unsupported parameter values");
   end

   // edit buffer, slot store and slot lengths; a slot of length zero is empty
   osc_step_t edit_q [NSTEP];
   osc_step_t slot_mem_q [NWORD];
   logic [7:0] slot_len_q [`OSC_SLOTS];
   // settings written by the host
   logic [3:0] slot_sel_q;
   logic [3:0] chain_q;
   logic [15:0] repeat_q;
   logic [7:0] step_sel_q;
   logic [7:0] total_q;
   // sequencer position and hold timer
   osc_state_t state_q;
   logic [3:0] run_slot_q;
   logic [7:0] run_step_q;
   logic [15:0] rep_left_q;
   logic [23:0] tick_q;
   logic [17:0] units_q;
   // save copy position
   logic [7:0] copy_q;
   logic [3:0] copy_slot_q;

   // decoded command strobe and the addressed step word
   logic take;
   logic ok;
   logic [7:0] sel_idx;
   logic [10:0] run_addr;
   osc_step_t run_word;
   logic pass_done;

   // saving blocks new commands, so the copy never races a step edit
   assign take = clk_en && cmd_valid && cmd_ready;
   assign sel_idx = step_sel_q - 8'h01;
   assign run_addr = 11'((run_slot_q - 4'h1) * NSTEP) + 11'(run_step_q) - 11'h001;
   assign run_word = slot_mem_q[run_addr];
   assign pass_done = run_step_q > slot_len_q[run_slot_q - 4'h1];

   // range check of a write; plain commands and queries pass, except a channel-2 query on a single-channel unit
   always_comb begin
      ok = 1'b1;
      if (!cmd.query) begin
         case (cmd.op)
            OSC_OP_SLOT_SEL: ok = cmd.value >= `OSC_SLOT_MIN && cmd.value <= `OSC_SLOTS;
            OSC_OP_CHAIN: ok = cmd.value <= `OSC_SLOTS;
            OSC_OP_REPEAT: ok = cmd.value >= `OSC_REP_MIN && cmd.value <= `OSC_REP_MAX;
            OSC_OP_STEP_SEL: ok = cmd.value >= `OSC_STEP_MIN && cmd.value <= `OSC_STEP_MAX;
            OSC_OP_CUR1: ok = cmd.value <= 32'(CUR_MAX);
            OSC_OP_CUR2: ok = DUAL && cmd.value <= 32'(CUR_MAX);
            OSC_OP_HOLD: ok = cmd.value >= `OSC_HOLD_MIN && cmd.value <= `OSC_HOLD_MAX;
            OSC_OP_TOTAL: ok = cmd.value >= `OSC_TOTAL_MIN && cmd.value <= `OSC_STEP_MAX;
            default: ok = 1'b1;
         endcase
      end else if (cmd.op == OSC_OP_CUR2) begin
         ok = DUAL;
      end
   end

   // settings; a refused write leaves them alone
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         slot_sel_q <= `OSC_SLOT_RST;
         chain_q <= `OSC_CHAIN_RST;
         repeat_q <= `OSC_REP_RST;
         step_sel_q <= `OSC_STEP_RST;
         total_q <= `OSC_TOTAL_RST;
      end else if (take && ok && !cmd.query) begin
         case (cmd.op)
            OSC_OP_SLOT_SEL: slot_sel_q <= cmd.value[3:0];
            OSC_OP_CHAIN: chain_q <= cmd.value[3:0];
            OSC_OP_REPEAT: repeat_q <= cmd.value[15:0];
            OSC_OP_STEP_SEL: step_sel_q <= cmd.value[7:0];
            OSC_OP_TOTAL: total_q <= cmd.value[7:0];
            default: ;
         endcase
      end
   end

   // edit buffer of the sequence being composed
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NSTEP; i++) begin
            edit_q[i] <= '{cur1: 16'h0000, cur2: 16'h0000, hold: `OSC_HOLD_RST};
         end
      end else if (take && ok && !cmd.query) begin
         case (cmd.op)
            OSC_OP_CUR1: edit_q[sel_idx].cur1 <= cmd.value[15:0];
            OSC_OP_CUR2: edit_q[sel_idx].cur2 <= cmd.value[15:0];
            OSC_OP_HOLD: edit_q[sel_idx].hold <= cmd.value[17:0];
            default: ;
         endcase
      end
   end

   // slot lengths: zero marks an erased slot, so clearing costs one cycle
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < `OSC_SLOTS; i++) begin
            slot_len_q[i] <= 8'h00;
         end
      end else if (take && !cmd.query && cmd.op == OSC_OP_CLEAR) begin
         slot_len_q[slot_sel_q - 4'h1] <= 8'h00;
      end else if (take && !cmd.query && cmd.op == OSC_OP_CLEAR_ALL) begin
         for (int i = 0; i < `OSC_SLOTS; i++) begin
            slot_len_q[i] <= 8'h00;
         end
      end else if (clk_en && state_q == OSC_SAVE && copy_q == total_q - 8'h01) begin
         slot_len_q[copy_slot_q - 4'h1] <= total_q;
      end
   end

   // slot memory is written one step per cycle by the save copy; no reset, contents
   // are only visible through a non-zero slot length
   always_ff @(posedge core_clk) begin
      if (clk_en && state_q == OSC_SAVE) begin
         slot_mem_q[11'((copy_slot_q - 4'h1) * NSTEP) + 11'(copy_q)] <= edit_q[copy_q];
      end
   end

   // save copy counter and slot
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         copy_q <= 8'h00;
         copy_slot_q <= 4'h1;
      end else if (take && !cmd.query && cmd.op == OSC_OP_SAVE) begin
         copy_q <= 8'h00;
         copy_slot_q <= slot_sel_q;
      end else if (clk_en && state_q == OSC_SAVE) begin
         copy_q <= copy_q + 8'h01;
      end
   end

   // sequencer state; a run write of 0 stops at once, saving is refused while running
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_q <= OSC_IDLE;
         run_slot_q <= 4'h1;
         run_step_q <= 8'h01;
         rep_left_q <= `OSC_REP_RST;
      end else if (clk_en) begin
         case (state_q)
            OSC_IDLE: begin
               if (take && !cmd.query && cmd.op == OSC_OP_SAVE) begin
                  state_q <= OSC_SAVE;
               end else if (take && !cmd.query && cmd.op == OSC_OP_RUN && cmd.value != 0) begin
                  state_q <= OSC_LOAD;
                  run_slot_q <= slot_sel_q;
                  run_step_q <= 8'h01;
                  rep_left_q <= repeat_q;
               end
            end
            OSC_SAVE: begin
               if (copy_q == total_q - 8'h01) state_q <= OSC_IDLE;
            end
            // a finished pass either repeats, follows the chain or ends the run
            OSC_LOAD: begin
               if (take && !cmd.query && cmd.op == OSC_OP_RUN && cmd.value == 0) begin
                  state_q <= OSC_IDLE;
               end else if (!pass_done) begin
                  state_q <= OSC_HOLD;
               end else if (rep_left_q > 16'h0001) begin
                  rep_left_q <= rep_left_q - 16'h0001;
                  run_step_q <= 8'h01;
               end else if (chain_q != 4'h0) begin
                  run_slot_q <= chain_q;
                  run_step_q <= 8'h01;
                  rep_left_q <= 16'h0001;
               end else begin
                  state_q <= OSC_IDLE;
               end
            end
            OSC_HOLD: begin
               if (take && !cmd.query && cmd.op == OSC_OP_RUN && cmd.value == 0) begin
                  state_q <= OSC_IDLE;
               end else if (units_q == 18'h00000 && tick_q == 24'h000000) begin
                  state_q <= OSC_LOAD;
                  run_step_q <= run_step_q + 8'h01;
               end
            end
            default: state_q <= OSC_IDLE;
         endcase
      end
   end

   // hold timer: 10 ms units counted down in ticks of TICK_CYCLES clocks
   // the load cycle between steps adds one clock to every step; kept for a simpler timer
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tick_q <= 24'h000000;
         units_q <= 18'h00000;
      end else if (clk_en) begin
         if (state_q == OSC_LOAD) begin
            tick_q <= 24'(TICK_CYCLES - 1);
            units_q <= run_word.hold - 18'h00001;
         end else if (state_q == OSC_HOLD) begin
            if (tick_q != 24'h000000) begin
               tick_q <= tick_q - 24'h000001;
            end else if (units_q != 18'h00000) begin
               tick_q <= 24'(TICK_CYCLES - 1);
               units_q <= units_q - 18'h00001;
            end
         end
      end
   end

   // set-points to the regulation stage, latched as each step begins
   // set_cur2 reads zero on single-channel builds
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         set_cur1 <= 16'h0000;
         set_cur2 <= 16'h0000;
         step_strobe <= 1'b0;
         run_active <= 1'b0;
      end else if (clk_en) begin
         step_strobe <= state_q == OSC_LOAD && !pass_done;
         if (state_q == OSC_LOAD && !pass_done) begin
            set_cur1 <= run_word.cur1;
            set_cur2 <= DUAL ? run_word.cur2 : 16'h0000;
         end
         run_active <= state_q == OSC_LOAD || state_q == OSC_HOLD;
      end
   end

   // command handshake and answer one cycle after a command is taken
   // cmd_ready drops as a save is taken so no edit can race the copy
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else if (clk_en) begin
         cmd_ready <= !(state_q == OSC_SAVE) && !(take && !cmd.query && cmd.op == OSC_OP_SAVE);
         rsp_valid <= take;
         if (take) begin
            rsp.err <= !ok || (!cmd.query && cmd.op == OSC_OP_SAVE && state_q != OSC_IDLE);
            rsp.data <= 32'h00000000;
            if (cmd.query) begin
               case (cmd.op)
                  OSC_OP_SLOT_SEL: rsp.data <= 32'(slot_sel_q);
                  OSC_OP_CHAIN: rsp.data <= 32'(chain_q);
                  OSC_OP_REPEAT: rsp.data <= 32'(repeat_q);
                  OSC_OP_RUN: rsp.data <= 32'(state_q == OSC_LOAD || state_q == OSC_HOLD);
                  OSC_OP_STEP_SEL: rsp.data <= 32'(step_sel_q);
                  OSC_OP_CUR1: rsp.data <= 32'(edit_q[sel_idx].cur1);
                  OSC_OP_CUR2: rsp.data <= DUAL ? 32'(edit_q[sel_idx].cur2) : 32'h0;
                  OSC_OP_HOLD: rsp.data <= 32'(edit_q[sel_idx].hold);
                  OSC_OP_TOTAL: rsp.data <= 32'(total_q);
                  default: rsp.data <= 32'h00000000;
               endcase
            end
         end
      end
   end
endmodule // osc_ctrl

// ### osc_checker.sv
// assertions watching the sequence controller ports
`timescale 1ns/100ps
module osc_checker #(
   parameter logic [15:0] CUR_MAX = 16'hffff
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic cmd_valid,
   input osc_pkg::osc_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input osc_pkg::osc_rsp_t rsp,
   input wire logic run_active,
   input wire logic step_strobe,
   input wire logic [15:0] set_cur1,
   input wire logic [15:0] set_cur2
);
   import osc_pkg::*;
   osc_cmd_t cq;
   logic take, wr, run_req;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // strobes of a taken command, so an answer can be paired with its cause
   assign take = clk_en & cmd_valid & cmd_ready;
   assign wr = rsp_valid & ~cq.query;
   assign run_req = take & ~cmd.query & (cmd.op == OSC_OP_RUN) & (cmd.value != 32'h0);
   // last taken command; the answer comes exactly one cycle later
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) cq <= '0;
      else if (take) cq <= cmd;
   end
   slot_range_a: assert property (wr && cq.op == OSC_OP_SLOT_SEL |->
      rsp.err == !(cq.value inside {[1:10]})) else $error("slot range wrong");
   chain_range_a: assert property (wr && cq.op == OSC_OP_CHAIN |->
      rsp.err == !(cq.value inside {[0:10]})) else $error("chain range wrong");
   repeat_range_a: assert property (wr && cq.op == OSC_OP_REPEAT |->
      rsp.err == !(cq.value inside {[1:50000]})) else $error("repeat range wrong");
   step_range_a: assert property (wr && cq.op == OSC_OP_STEP_SEL |->
      rsp.err == !(cq.value inside {[1:150]})) else $error("step range wrong");
   total_range_a: assert property (wr && cq.op == OSC_OP_TOTAL |->
      rsp.err == !(cq.value inside {[2:150]})) else $error("total range wrong");
   hold_range_a: assert property (wr && cq.op == OSC_OP_HOLD |->
      rsp.err == !(cq.value inside {[1:200000]})) else $error("hold range wrong");
   cur_range_a: assert property (wr && (cq.op == OSC_OP_CUR1 || cq.op == OSC_OP_CUR2) |->
      rsp.err == (cq.value > CUR_MAX)) else $error("current range wrong");
   save_stall_a: assert property (take && cmd.op == OSC_OP_SAVE && !cmd.query && !run_active
      |-> ##[1:2] !cmd_ready) else $error("save did not stall commands");
   run_start_a: assert property ($rose(run_active) |-> $past(run_req, 2))
      else $error("run began without a start");
   strobe_run_a: assert property (step_strobe |-> run_active) else $error("step while idle");
   cur_held_a: assert property ($changed(set_cur1) |-> step_strobe)
      else $error("set-point moved mid step");
endmodule // osc_checker

// ### osc_host.sv
// host model issuing commands and collecting answers
`timescale 1ns/100ps
module osc_host (
   input wire logic core_clk,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input osc_pkg::osc_rsp_t rsp,
   output logic cmd_valid,
   output osc_pkg::osc_cmd_t cmd
);
   import osc_pkg::*;
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // held from a falling edge until taken; an unanswered command returns unknown
   task automatic send(input osc_op_t op, input logic q, input logic [31:0] v,
         output osc_rsp_t r);
      int n;
      r = 'x;
      @(negedge core_clk);
      cmd_valid <= 1'b1;
      cmd <= '{op, q, v};
      for (n = 0; n < 999 && cmd_ready !== 1'b1; n++) @(negedge core_clk);
      @(negedge core_clk);
      if (rsp_valid === 1'b1) r = rsp;
      cmd_valid <= 1'b0;
      cmd <= ~cmd; // released lines do not keep the last value
   endtask
endmodule // osc_host

// ### tb_top.sv
// self-checking bench of the output sequence slot controller
`timescale 1ns/100ps
module tb_top;
   import osc_pkg::*;
   localparam int TICK = 4;
   logic core_clk, reset, clk_en, cmd_valid, cmd_ready, rsp_valid, run_active, step_strobe;
   osc_cmd_t cmd;
   osc_rsp_t rsp, r;
   logic [15:0] set_cur1, set_cur2, x;
   logic [15:0] c1 [1:3], c2 [1:3];
   logic [31:0] v;
   int n_mismatch = 0, tests_run = 0, i;
   time ts, t0;
   osc_op_t ops [8] = '{OSC_OP_SLOT_SEL, OSC_OP_CHAIN, OSC_OP_REPEAT, OSC_OP_STEP_SEL,
      OSC_OP_TOTAL, OSC_OP_HOLD, OSC_OP_CUR1, OSC_OP_CUR2};
   // lowest legal values double as the reset values
   logic [31:0] lo [8] = '{1, 0, 1, 1, 2, 1, 0, 0};
   logic [31:0] hi [8] = '{10, 10, 50000, 150, 150, 200000, 32'hffff, 32'hffff};
   osc_ctrl #(.TICK_CYCLES(TICK)) osc_ctrl_i (.core_clk(core_clk), .reset(reset),
      .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .run_active(run_active), .step_strobe(step_strobe),
      .set_cur1(set_cur1), .set_cur2(set_cur2));
   osc_host osc_host_i (.core_clk(core_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp(rsp), .cmd_valid(cmd_valid), .cmd(cmd));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   function automatic logic bad(int k, logic [31:0] val);
      return !(val >= lo[k] && val <= hi[k]);
   endfunction
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // writes compare only the error bit, queries the whole answer
   task automatic cmd_do(input osc_op_t op, input logic q, input logic [31:0] val,
         input logic [32:0] exp);
      osc_host_i.send(op, q, val, r);
      chk(q ? r : {r.err, 32'h0}, exp);
   endtask
   task automatic put(input osc_op_t op, input logic [31:0] val);
      cmd_do(op, 1'b0, val, 33'h0);
   endtask
   task automatic wt(input int k, input logic [31:0] val);
      cmd_do(ops[k], 1'b0, val, {bad(k, val), 32'h0});
   endtask
   // next applied step must come and carry both set-points
   task automatic strobe(input logic [15:0] e1, input logic [15:0] e2);
      int n;
      @(negedge core_clk);
      for (n = 0; n < 200 && step_strobe !== 1'b1; n++) @(negedge core_clk);
      ts = $time;
      chk({step_strobe, set_cur2, set_cur1}, {1'b1, e2, e1});
   endtask
   // nothing may be applied and the run must be over; a fixed span, as we look for silence
   task automatic idle;
      int n, s;
      s = 0;
      for (n = 0; n < 20; n++) begin
         @(negedge core_clk);
         if (step_strobe !== 1'b0) s++;
      end
      chk(33'(s) + {32'h0, run_active}, 33'h0);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      void'($urandom(39));
      repeat (8) @(negedge core_clk);
      reset = 1'b0;
      repeat (2) @(negedge core_clk);
      for (i = 0; i < 8; i++) cmd_do(ops[i], 1'b1, 32'h0, {1'b0, lo[i]});
      cmd_do(OSC_OP_RUN, 1'b1, 32'h0, 33'h0);
      $display("reset values done");
      // both edges of every range, refusals leave the old value, then a random legal one
      for (i = 0; i < 8; i++) begin
         v = lo[i] + $urandom % (hi[i] - lo[i] + 32'h1);
         wt(i, hi[i]);
         wt(i, lo[i] - 32'h1);
         wt(i, hi[i] + 32'h1);
         cmd_do(ops[i], 1'b1, 32'h0, {1'b0, hi[i]});
         wt(i, v);
         cmd_do(ops[i], 1'b1, 32'h0, {1'b0, v});
      end
      $display("ranges done");
      // three steps of three ticks; slot 2 keeps them, slot 3 differs in step 1
      put(OSC_OP_TOTAL, 32'h3);
      for (i = 1; i <= 3; i++) begin
         c1[i] = 16'($urandom);
         c2[i] = 16'($urandom);
         put(OSC_OP_STEP_SEL, 32'(i));
         put(OSC_OP_CUR1, {16'h0, c1[i]});
         put(OSC_OP_CUR2, {16'h0, c2[i]});
         put(OSC_OP_HOLD, 32'h3);
      end
      put(OSC_OP_SLOT_SEL, 32'h2);
      put(OSC_OP_SAVE, 32'h0);
      x = ~c1[1];
      put(OSC_OP_STEP_SEL, 32'h1);
      put(OSC_OP_CUR1, {16'h0, x});
      put(OSC_OP_SLOT_SEL, 32'h3);
      put(OSC_OP_SAVE, 32'h0);
      // two passes of slot 2, then the chained slot 3
      put(OSC_OP_SLOT_SEL, 32'h2);
      put(OSC_OP_REPEAT, 32'h2);
      put(OSC_OP_CHAIN, 32'h3);
      put(OSC_OP_RUN, 32'h1);
      strobe(c1[1], c2[1]);
      t0 = ts;
      strobe(c1[2], c2[2]);
      // a step lasts its hold time plus the one load cycle between steps
      chk(33'((ts - t0) / 5), 33'(3 * TICK + 1));
      strobe(c1[3], c2[3]);
      for (i = 1; i <= 3; i++) strobe(c1[i], c2[i]);
      strobe(x, c2[1]);
      put(OSC_OP_CHAIN, 32'h0);
      strobe(c1[2], c2[2]);
      strobe(c1[3], c2[3]);
      idle();
      $display("run and chain done");
      // clearing slot 3 leaves slot 2; clear-all empties slot 2 as well
      put(OSC_OP_SLOT_SEL, 32'h3);
      put(OSC_OP_CLEAR, 32'h0);
      put(OSC_OP_RUN, 32'h1);
      idle();
      put(OSC_OP_SLOT_SEL, 32'h2);
      put(OSC_OP_REPEAT, 32'h1);
      put(OSC_OP_RUN, 32'h1);
      strobe(c1[1], c2[1]);
      // a low clock enable freezes the step, so it lasts the frozen cycles longer
      t0 = ts;
      clk_en = 1'b0;
      repeat (6) @(negedge core_clk);
      clk_en = 1'b1;
      cmd_do(OSC_OP_RUN, 1'b1, 32'h0, 33'h1);
      strobe(c1[2], c2[2]);
      chk(33'((ts - t0) / 5), 33'(3 * TICK + 1 + 6));
      strobe(c1[3], c2[3]);
      idle();
      put(OSC_OP_CLEAR_ALL, 32'h0);
      put(OSC_OP_RUN, 32'h1);
      idle();
      cmd_do(OSC_OP_RUN, 1'b1, 32'h0, 33'h0);
      $display("clear done");
      report_and_stop();
   end
endmodule // tb_top
bind osc_ctrl osc_checker #(.CUR_MAX(CUR_MAX)) osc_checker_i (.core_clk(core_clk),
   .reset(reset), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
   .rsp_valid(rsp_valid), .rsp(rsp), .run_active(run_active), .step_strobe(step_strobe),
   .set_cur1(set_cur1), .set_cur2(set_cur2));
